// >>> rtl/rdsbr_defs.svh
// offsets, reset values and timing counts of the block buffer readout
// assumes inclusion by bare name from the main module and the testbench
`ifndef RDSBR_DEFS_SVH
`define RDSBR_DEFS_SVH

`define RDSBR_CTRL_OFS    8'h00
`define RDSBR_STAT_OFS    8'h04
`define RDSBR_CTRL_RST    8'h00

`define RDSBR_STAT_EMPTY  0
`define RDSBR_STAT_FULL   1
`define RDSBR_STAT_REQ    2
`define RDSBR_STAT_STBY   3
`define RDSBR_STAT_SHOLD  4
`define RDSBR_STAT_CNT    8

`define RDSBR_THR_00      5'd1
`define RDSBR_THR_10      5'd4
`define RDSBR_THR_01      5'd8
`define RDSBR_THR_11      5'd12

`define RDSBR_ADDR_BITS   6'd8
`define RDSBR_WR_BITS     6'd8

`define RDSBR_TDO_NS      265000
`define RDSBR_CLK_NS      20

`endif

// >>> rtl/rdsbr_pkg.sv
// types shared by the block buffer readout modules
// uses nothing from the defines header and does not include it
package rdsbr_pkg;

  typedef struct packed {
    logic [9:0]  check;
    logic [15:0] info;
  } rdsbr_block_t;

  typedef struct packed {
    logic [1:0] pending_threshold;
    logic       station_detect_strictness;
    logic       soft_flag_strictness;
    logic       test_bit_3;
    logic       test_bit_2;
    logic       test_bit_1;
    logic       test_bit_0;
  } rdsbr_ctrl_t;

  typedef enum logic [2:0] {
    RDSBR_IDLE,
    RDSBR_ADDR,
    RDSBR_READ,
    RDSBR_WRITE,
    RDSBR_IGNORE
  } rdsbr_mode_t;

  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
  } rdsbr_ahb_in_t;

  typedef struct packed {
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
  } rdsbr_ahb_out_t;

endpackage

// >>> rtl/rdsbr_sync.sv
// two flip-flop synchroniser for a group of pin levels
// assumes each bit is a slow level compared with clk_sys
`timescale 1ns/1ps
module rdsbr_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_sys,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } rdsbr_sync_state_t;

  rdsbr_sync_state_t s;
  rdsbr_sync_state_t next_s;

  always_comb begin
    next_s        = s;
    next_s.meta   = d;
    next_s.stable = s.meta;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign q = s.stable;
endmodule

// >>> rtl/rdsbr_top.sv
// decoded block buffer, serial readout with request line, ahb-lite regs
// assumes clk_sys at 50 MHz; serial pins arrive asynchronously
//
// Behaviour
// - test pins select normal or standby
// - stricter soft flag when first control set
// - stricter rds detect when second control set
// - control bits reset to zero
// - transfers open with eight-bit address byte
// - serial access only with oscillator running
// - buffer holds twenty-four decoded blocks
// - threshold 00 requests after one block
// - line held high 265 us after readout
// - empty stays high, remaining data re-requests
// - sync reset holds request until sync
// - first request safe for 480 ms
// - re-request safe for 20 ms
// - several blocks read in one enable
// - each readout carries empty, full flags
// - no pending request returns all zeros
// - threshold codes select 1, 4, 8, 12
`timescale 1ns/1ps
`include "rdsbr_defs.svh"
module rdsbr_top #(
  parameter int         DEPTH     = 24,
  parameter int         TDO_CYC   = (`RDSBR_TDO_NS + `RDSBR_CLK_NS - 1)
                                    / `RDSBR_CLK_NS,
  parameter logic [7:0] READ_ADDR = 8'h5a,  // arbitrary value
  parameter logic [7:0] WRITE_ADDR = 8'h5b  // arbitrary value
) (
  input  wire logic                   clk_sys,
  input  wire logic                   rst,
  input  wire rdsbr_pkg::rdsbr_ahb_in_t ahb_i,
  output rdsbr_pkg::rdsbr_ahb_out_t   ahb_o,
  input  wire logic                   blk_valid,
  input  wire rdsbr_pkg::rdsbr_block_t blk,
  input  wire logic                   sync_reset,
  input  wire logic                   sync_achieved,
  input  wire logic                   soft_flag_normal,
  input  wire logic                   soft_flag_strict,
  input  wire logic                   rds_present_normal,
  input  wire logic                   rds_present_strict,
  output logic                        soft_decision_flag_out,
  output logic                        rds_present_indicator,
  input  wire logic                   chip_enable,
  input  wire logic                   serial_shift_strobe,
  input  wire logic                   serial_input_line,
  input  wire logic                   osc_running,
  input  wire logic                   test_pin_one,
  input  wire logic                   test_pin_two,
  output logic                        data_out_o,
  output logic                        data_out_oe,
  output logic                        osc_stop,
  output logic                        test_mode
);
  import rdsbr_pkg::*;

  localparam int FRAME = 2 + $bits(rdsbr_block_t);
  localparam int TW    = $clog2(TDO_CYC + 1);

  generate
    if (DEPTH < 12 || DEPTH > 31) begin : g_bad_depth
      $error("DEPTH must lie in 12..31");
    end
    if (TDO_CYC < 1) begin : g_bad_tdo
      $error("TDO_CYC must be at least one");
    end
  endgenerate

  typedef struct packed {
    rdsbr_ctrl_t                 ctrl;
    rdsbr_block_t [DEPTH-1:0]    mem;
    logic [4:0]                  wr_ptr;
    logic [4:0]                  rd_ptr;
    logic [4:0]                  count;
    logic [TW-1:0]               hold_cnt;
    logic                        sync_hold;
    logic                        ce_q;
    logic                        stb_q;
    rdsbr_mode_t                 mode;
    logic [5:0]                  bitcnt;
    logic [7:0]                  addr;
    logic [7:0]                  wdata;
    logic [FRAME-1:0]            shreg;
    logic                        rd_real;
    logic                        ahb_wr;
    logic [7:0]                  ahb_addr;
    logic [31:0]                 hrdata;
    logic                        do_oe;
    logic                        soft_out;
    logic                        rds_out;
    logic                        stby;
    logic                        tmode;
  } rdsbr_state_t;

  rdsbr_state_t s;
  rdsbr_state_t next_s;

  logic [4:0] pin_s;
  logic       ce_s;
  logic       stb_s;
  logic       di_s;
  logic       osc_s;
  logic       t1_s;
  logic       t2_s;

  rdsbr_sync #(
    .W (5)
  ) u_pin_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .d       ({chip_enable, serial_shift_strobe, serial_input_line,
               osc_running, test_pin_one}),
    .q       (pin_s)
  );

  logic t2_meta;
  assign {ce_s, stb_s, di_s, osc_s, t1_s} = pin_s;

  rdsbr_sync #(
    .W (1)
  ) u_t2_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .d       (test_pin_two),
    .q       (t2_meta)
  );
  assign t2_s = t2_meta;

  function automatic logic [4:0] ptr_inc(input logic [4:0] p);
    if (p == 5'(DEPTH - 1)) begin
      ptr_inc = 5'd0;
    end else begin
      ptr_inc = p + 5'd1;
    end
  endfunction

  function automatic logic [4:0] thr_of(input logic [1:0] code);
    // bit 0 is the first threshold bit, bit 1 the second
    case (code)
      2'b00:   thr_of = `RDSBR_THR_00;
      2'b01:   thr_of = `RDSBR_THR_10;
      2'b10:   thr_of = `RDSBR_THR_01;
      default: thr_of = `RDSBR_THR_11;
    endcase
  endfunction

  // empty means nothing left after this block
  function automatic logic [FRAME-1:0] frame_of(input logic real_blk,
                                                input rdsbr_block_t b,
                                                input logic [4:0] cnt);
    if (!real_blk) begin
      frame_of = '0;
    end else begin
      frame_of = {b, cnt == 5'(DEPTH), cnt <= 5'd1};
    end
  endfunction

  logic       ce_rise;
  logic       ce_fall;
  logic       stb_rise;
  logic       serial_ok;
  logic       req_now;
  logic       push;
  logic       pop;
  logic [7:0] addr_full;
  logic [4:0] cnt_after;
  logic [4:0] rd_after;
  logic [31:0] rd_mux;

  always_comb begin
    next_s    = s;
    push      = blk_valid;
    pop       = 1'b0;
    ce_rise   = ce_s && !s.ce_q;
    ce_fall   = !ce_s && s.ce_q;
    stb_rise  = stb_s && !s.stb_q;
    serial_ok = osc_s && !s.stby;
    req_now   = (s.hold_cnt == '0) && !s.sync_hold
                && (s.count >= thr_of(s.ctrl.pending_threshold));
    addr_full = {di_s, s.addr[7:1]};
    cnt_after = s.count - 5'd1;
    rd_after  = ptr_inc(s.rd_ptr);

    next_s.ce_q  = ce_s;
    next_s.stb_q = stb_s;

    // standby needs first pin low and second high
    next_s.stby  = !t1_s && t2_s;
    next_s.tmode = t1_s;

    next_s.soft_out = s.ctrl.soft_flag_strictness
                      ? soft_flag_strict : soft_flag_normal;
    next_s.rds_out  = s.ctrl.station_detect_strictness
                      ? rds_present_strict
                      : rds_present_normal;

    // ahb-lite: zero wait states, read data fetched in the address phase
    rd_mux = 32'h0000_0000;
    if (ahb_i.haddr[7:0] == `RDSBR_CTRL_OFS) begin
      rd_mux[7:0] = s.ctrl;
    end else if (ahb_i.haddr[7:0] == `RDSBR_STAT_OFS) begin
      rd_mux[`RDSBR_STAT_EMPTY] = (s.count == 5'd0);
      rd_mux[`RDSBR_STAT_FULL]  = (s.count == 5'(DEPTH));
      rd_mux[`RDSBR_STAT_REQ]   = s.do_oe && !ce_s;
      rd_mux[`RDSBR_STAT_STBY]  = s.stby;
      rd_mux[`RDSBR_STAT_SHOLD] = s.sync_hold;
      rd_mux[`RDSBR_STAT_CNT +: 5] = s.count;
    end
    next_s.ahb_wr = 1'b0;
    if (ahb_i.hsel && ahb_i.hready && ahb_i.htrans[1]) begin
      next_s.ahb_wr   = ahb_i.hwrite;
      next_s.ahb_addr = ahb_i.haddr[7:0];
      if (!ahb_i.hwrite) begin
        next_s.hrdata = rd_mux;
      end
    end
    if (s.ahb_wr && s.ahb_addr == `RDSBR_CTRL_OFS) begin
      next_s.ctrl = ahb_i.hwdata[7:0];
    end

    // serial link, sampled on rising strobe, least bit first
    if (ce_rise) begin
      next_s.mode   = serial_ok ? RDSBR_ADDR : RDSBR_IGNORE;
      next_s.bitcnt = 6'd0;
      next_s.addr   = 8'h00;
    end else if (ce_s && stb_rise) begin
      case (s.mode)
        RDSBR_ADDR: begin
          next_s.addr   = addr_full;
          next_s.bitcnt = s.bitcnt + 6'd1;
          if (s.bitcnt == `RDSBR_ADDR_BITS - 6'd1) begin
            next_s.bitcnt = 6'd0;
            if (addr_full == READ_ADDR) begin
              next_s.mode    = RDSBR_READ;
              next_s.rd_real = req_now;
              next_s.shreg   = frame_of(req_now, s.mem[s.rd_ptr],
                                        s.count);
            end else if (addr_full == WRITE_ADDR) begin
              next_s.mode = RDSBR_WRITE;
            end else begin
              next_s.mode = RDSBR_IGNORE;
            end
          end
        end
        RDSBR_READ: begin
          next_s.shreg  = s.shreg >> 1;
          next_s.bitcnt = s.bitcnt + 6'd1;
          if (s.bitcnt == 6'(FRAME - 1)) begin
            // next block follows in the same enable window
            next_s.bitcnt = 6'd0;
            if (s.rd_real) begin
              pop            = 1'b1;
              next_s.rd_real = (cnt_after != 5'd0);
              next_s.shreg   = frame_of(cnt_after != 5'd0,
                                        s.mem[rd_after], cnt_after);
            end else begin
              next_s.shreg = '0;
            end
          end
        end
        RDSBR_WRITE: begin
          if (s.bitcnt < `RDSBR_WR_BITS) begin
            next_s.wdata  = {di_s, s.wdata[7:1]};
            next_s.bitcnt = s.bitcnt + 6'd1;
          end
        end
        default: begin
          next_s.mode = s.mode;
        end
      endcase
    end else if (ce_fall) begin
      if (s.mode == RDSBR_WRITE && s.bitcnt == `RDSBR_WR_BITS) begin
        next_s.ctrl = s.wdata;
      end
      if (s.mode == RDSBR_READ) begin
        next_s.hold_cnt = TW'(TDO_CYC);
      end
      next_s.mode = RDSBR_IDLE;
    end

    if (ce_fall && s.mode == RDSBR_READ) begin
      next_s.hold_cnt = TW'(TDO_CYC);
    end else if (s.hold_cnt != '0) begin
      next_s.hold_cnt = s.hold_cnt - TW'(1);
    end

    if (sync_reset) begin
      next_s.sync_hold = 1'b1;
    end else if (sync_achieved) begin
      next_s.sync_hold = 1'b0;
    end

    // buffer; a full write drops the oldest unread block
    if (pop) begin
      next_s.rd_ptr = rd_after;
    end
    if (push) begin
      next_s.mem[s.wr_ptr] = blk;
      next_s.wr_ptr        = ptr_inc(s.wr_ptr);
      if (s.count == 5'(DEPTH) && !pop) begin
        next_s.rd_ptr = rd_after;
      end
    end
    if (push && !pop && s.count != 5'(DEPTH)) begin
      next_s.count = s.count + 5'd1;
    end else if (pop && !push) begin
      next_s.count = cnt_after;
    end

    // open drain: enable means pull low
    if (next_s.ce_q) begin
      next_s.do_oe = (next_s.mode == RDSBR_READ) && !next_s.shreg[0];
    end else begin
      next_s.do_oe = (next_s.hold_cnt == '0) && !next_s.sync_hold
                     && (next_s.count
                         >= thr_of(next_s.ctrl.pending_threshold));
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s          <= '0;
      s.ctrl     <= `RDSBR_CTRL_RST;
      s.mode     <= RDSBR_IDLE;
    end else begin
      s <= next_s;
    end
  end

  assign ahb_o.hrdata           = s.hrdata;
  assign ahb_o.hreadyout        = 1'b1;
  assign ahb_o.hresp            = 1'b0;
  assign soft_decision_flag_out = s.soft_out;
  assign rds_present_indicator  = s.rds_out;
  assign data_out_o             = 1'b0;
  assign data_out_oe            = s.do_oe;
  assign osc_stop               = s.stby;
  assign test_mode              = s.tmode;
endmodule

// >>> sim/rdsbr_host.sv
// serial host model: frames on enable, strobe and data-in lines
// assumes line is the resolved open-drain level with its pull-up
`timescale 1ns/1ps
module rdsbr_host (
  input  wire logic clk_sys,
  input  wire logic line,
  output logic      chip_enable,
  output logic      serial_shift_strobe,
  output logic      serial_input_line
);
  initial begin
    chip_enable         = 1'b0;
    serial_shift_strobe = 1'b0;
    serial_input_line   = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // strobe idles low outside frames; 8 cycles a bit, 160 ns
  // low byte of a is the address, high byte the write data
  task automatic frame(input logic [15:0] a, input int n,
                       output logic [63:0] q);
    q = '0;
    chip_enable <= 1'b1;
    wt(4);
    for (int i = 0; i < 8 + n; i++) begin
      serial_shift_strobe <= 1'b0;
      if (i < 16) serial_input_line <= a[i];
      wt(4);
      if (i >= 8) q[i-8] = line;
      serial_shift_strobe <= 1'b1;
      wt(4);
    end
    serial_shift_strobe <= 1'b0;
    wt(4);
    chip_enable <= 1'b0;
    // released line must not keep the last bit
    serial_input_line <= ~serial_input_line;
    wt(4);
  endtask
endmodule

// >>> sim/rdsbr_top_assertions.sv
// pin checker for the block buffer readout
// assumes binding into rdsbr_top; sees its ports only
`timescale 1ns/1ps
module rdsbr_top_assertions #(
  parameter int TDO_CYC = 13250
) (
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic soft_flag_normal,
  input  wire logic soft_flag_strict,
  input  wire logic rds_present_normal,
  input  wire logic rds_present_strict,
  input  wire logic soft_decision_flag_out,
  input  wire logic rds_present_indicator,
  input  wire logic chip_enable,
  input  wire logic osc_running,
  input  wire logic test_pin_one,
  input  wire logic test_pin_two,
  input  wire logic data_out_oe,
  input  wire logic osc_stop,
  input  wire logic test_mode,
  input  wire logic sync_reset,
  input  wire logic sync_achieved
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  int   hold;
  int   ce_run;
  logic rd_seen;
  // only frames whose data pulled the line restart the hold;
  // saturating, so idle time never wraps into a false hold
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      hold    <= TDO_CYC;
      ce_run  <= 0;
      rd_seen <= 1'b0;
    end else begin
      if (!chip_enable) ce_run <= 0;
      else if (ce_run < 8) ce_run <= ce_run + 1;
      if (!chip_enable) rd_seen <= 1'b0;
      else if (ce_run > 4 && data_out_oe) rd_seen <= 1'b1;
      if (chip_enable && rd_seen) hold <= 0;
      else if (hold < TDO_CYC) hold <= hold + 1;
    end
  end
  // enable low long enough that no data bit is still on the line
  sequence s_held;
    (!chip_enable)[*3] ##0 sync_reset
    ##1 (!sync_achieved && !chip_enable);
  endsequence
  sequence s_no_osc;
    (!osc_running && chip_enable)[*4];
  endsequence
  property p_tdo_hold;
    hold > 6 && hold < TDO_CYC |-> !data_out_oe;
  endproperty
  property p_stby_on;
    (!test_pin_one && test_pin_two)[*4] |=> osc_stop;
  endproperty
  property p_soft_same;
    soft_flag_normal == soft_flag_strict |=>
      soft_decision_flag_out == $past(soft_flag_normal);
  endproperty
  property p_rds_same;
    rds_present_normal == rds_present_strict |=>
      rds_present_indicator == $past(rds_present_normal);
  endproperty
  a_tdo_hold: assert property (p_tdo_hold)
    else $error("line pulled during post-read hold");
  a_sync_hold: assert property (s_held |=> !data_out_oe)
    else $error("request during sync hold");
  a_osc_ignore: assert property (s_no_osc |=> !data_out_oe)
    else $error("line driven without oscillator");
  a_stby_on: assert property (p_stby_on)
    else $error("standby not entered");
  a_stby_off: assert property ((!test_pin_two)[*4] |=> !osc_stop)
    else $error("oscillator stopped in normal mode");
  a_test_off: assert property ((!test_pin_one)[*4] |=> !test_mode)
    else $error("test mode without first pin");
  a_soft_same: assert property (p_soft_same)
    else $error("soft flag not from candidates");
  a_rds_same: assert property (p_rds_same)
    else $error("rds indicator not from candidates");
endmodule
bind rdsbr_top rdsbr_top_assertions #(.TDO_CYC(TDO_CYC)) i_chk (
  .clk_sys, .rst, .soft_flag_normal, .soft_flag_strict, .rds_present_normal,
  .rds_present_strict, .soft_decision_flag_out, .rds_present_indicator,
  .chip_enable, .osc_running, .test_pin_one, .test_pin_two, .data_out_oe,
  .osc_stop, .test_mode, .sync_reset, .sync_achieved);

// >>> sim/testbench.sv
// self-checking bench for the block buffer readout
// assumes the design, its defines header and the host model
`timescale 1ns/1ps
`include "rdsbr_defs.svh"
module testbench;
  import rdsbr_pkg::*;
  localparam int         TDO = 20;
  localparam logic [7:0] RA  = 8'h5a;
  localparam logic [7:0] WA  = 8'h5b;
  logic           clk_sys     = 1'b0;
  logic           rst         = 1'b1;
  rdsbr_ahb_in_t  ahb_m       = '0;
  rdsbr_block_t   blk         = '0;
  logic           blk_valid   = 1'b0;
  logic [5:0]     drv         = '0;
  logic           osc_running = 1'b0;
  logic           tp2         = 1'b0;
  rdsbr_ahb_in_t  ahb_i;
  rdsbr_ahb_out_t ahb_o;
  logic           ce, scl, sdi, line, soft_o, rds_o, oe, d_o, stop, tmode;
  logic [31:0]    rd;
  logic [63:0]    q;
  int             fail_count  = 0;
  int             checked     = 0;
  assign ahb_i = {ahb_m[71:1], ahb_o.hreadyout};
  assign line  = oe ? d_o : 1'b1;
  initial forever #10 clk_sys = ~clk_sys;
  rdsbr_top #(.TDO_CYC(TDO), .READ_ADDR(RA), .WRITE_ADDR(WA)) i_rdsbr_top (
    .clk_sys, .rst, .ahb_i, .ahb_o, .blk_valid, .blk,
    .sync_reset(drv[5]), .sync_achieved(drv[4]),
    .soft_flag_normal(drv[3]), .soft_flag_strict(drv[2]),
    .rds_present_normal(drv[1]), .rds_present_strict(drv[0]),
    .soft_decision_flag_out(soft_o), .rds_present_indicator(rds_o),
    .chip_enable(ce), .serial_shift_strobe(scl), .serial_input_line(sdi),
    .osc_running, .test_pin_one(1'b0), .test_pin_two(tp2),
    .data_out_o(d_o), .data_out_oe(oe), .osc_stop(stop), .test_mode(tmode));
  rdsbr_host i_rdsbr_host (.clk_sys, .line, .chip_enable(ce),
    .serial_shift_strobe(scl), .serial_input_line(sdi));
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    ahb_m.hsel   <= 1'b1;
    ahb_m.htrans <= 2'h2;
    ahb_m.haddr  <= {24'h0, a};
    ahb_m.hwrite <= w;
    ahb_m.hsize  <= 3'h2;
    do @(posedge clk_sys); while (ahb_o.hreadyout !== 1'b1);
    ahb_m.htrans <= 2'h0;
    ahb_m.hwdata <= d;
    do @(posedge clk_sys); while (ahb_o.hreadyout !== 1'b1);
    rd = ahb_o.hrdata;
  endtask
  function automatic rdsbr_block_t bv(input int i);
    return rdsbr_block_t'(26'h0155a00 + i * 26'h0010203);
  endfunction
  task automatic push(input int i);
    blk       <= bv(i);
    blk_valid <= 1'b1;
    wt(1);
    blk_valid <= 1'b0;
    wt(1);
  endtask
  task automatic do_reset();
    rst <= 1'b1;
    wt(10);
    rst <= 1'b0;
    wt(3);
  endtask
  task automatic rx(input int n);
    i_rdsbr_host.frame({8'h00, RA}, n, q);
  endtask
  task automatic t_reset();
    ahb(1'b0, `RDSBR_CTRL_OFS, '0);
    chk(rd, `RDSBR_CTRL_RST);
    ahb(1'b0, 8'h10, '0);
    chk(rd, '0);
    chk(oe, 1'b0);
    chk({ahb_o.hresp, d_o}, 2'b00);
    rx(28);
    chk(q, '0);
    wt(TDO + 10);
    $display("reset and empty read test done");
  endtask
  task automatic t_readout();
    for (int i = 0; i < 3; i++) push(i);
    wt(5);
    chk(oe, 1'b1);
    rx(56);
    chk(q[27:0], {bv(0), 2'b00});
    chk(q[55:28], {bv(1), 2'b00});
    wt(8);
    chk(oe, 1'b0);
    wt(TDO + 10);
    chk(oe, 1'b1);
    rx(28);
    chk(q[27:0], {bv(2), 2'b01});
    wt(TDO + 10);
    chk(oe, 1'b0);
    $display("readout test done");
  endtask
  task automatic t_thresh();
    logic [7:0] cv[4] = '{8'h00, 8'h40, 8'h80, 8'hc0};
    int         th[4] = '{1, 4, 8, 12};
    for (int k = 0; k < 4; k++) begin
      do_reset();
      ahb(1'b1, `RDSBR_CTRL_OFS, {24'h0, cv[k]});
      for (int i = 1; i < th[k]; i++) push(i);
      wt(5);
      chk(oe, 1'b0);
      push(0);
      wt(5);
      chk(oe, 1'b1);
    end
    $display("threshold test done");
  endtask
  task automatic t_over_sync();
    do_reset();
    for (int i = 0; i < 25; i++) push(i);
    ahb(1'b0, `RDSBR_STAT_OFS, '0);
    chk(rd[12:8], 5'd24);
    rx(28);
    chk(q[27:0], {bv(1), 2'b10});
    wt(TDO + 10);
    drv[5] <= 1'b1;
    wt(1);
    drv[5] <= 1'b0;
    wt(4);
    chk(oe, 1'b0);
    drv[4] <= 1'b1;
    wt(1);
    drv[4] <= 1'b0;
    wt(4);
    chk(oe, 1'b1);
    $display("overwrite and sync test done");
  endtask
  task automatic t_flags();
    for (int k = 0; k < 4; k++) begin
      ahb(1'b1, `RDSBR_CTRL_OFS, {26'h0, k[1:0], 4'h0});
      drv[3:0] <= 4'b0101;
      wt(4);
      chk({soft_o, rds_o}, {k[0], k[1]});
    end
    drv[3:0] <= 4'b1111;
    wt(4);
    chk({soft_o, rds_o}, 2'b11);
    drv[3:0] <= 4'b0000;
    // serial write of the control byte, then a short one that must drop
    i_rdsbr_host.frame({8'h20, WA}, 8, q);
    ahb(1'b0, `RDSBR_CTRL_OFS, '0);
    chk(rd, 32'h0000_0020);
    i_rdsbr_host.frame({8'h10, WA}, 7, q);
    ahb(1'b0, `RDSBR_CTRL_OFS, '0);
    chk(rd, 32'h0000_0020);
    ahb(1'b1, `RDSBR_CTRL_OFS, '0);
    $display("control bit test done");
  endtask
  task automatic t_stby();
    osc_running <= 1'b0;
    wt(2);
    rx(28);
    chk(q[27:0], 28'hfffffff);
    ahb(1'b0, `RDSBR_STAT_OFS, '0);
    chk(rd[12:8], 5'd23);
    osc_running <= 1'b1;
    tp2 <= 1'b1;
    wt(6);
    chk({stop, tmode}, 2'b10);
    tp2 <= 1'b0;
    wt(6);
    chk(stop, 1'b0);
    $display("standby test done");
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    wt(10);
    rst <= 1'b0;
    wt(3);
    osc_running <= 1'b1;
    wt(3);
    t_reset();
    t_readout();
    t_thresh();
    t_over_sync();
    t_flags();
    t_stby();
    report_and_stop();
  end
  // whole run is a few thousand cycles; 1 ms means a hang
  initial begin
    #1000000;
    fail_count++;
    report_and_stop();
  end
endmodule
